/* File: hdl/sbc_regmap.sv */
`timescale 1ns/1ps
// Functional notes
// - Sixteen-bit frame: address, mode, then data
// - Mode bit zero reads without changing registers
// - Mode bit one stores data byte
// - Data bits D0..D7 are frame bits 8..15
// - Extra bytes access next valid address
// - Power-on reset loads defined values
// - Restart loads restart values, keeps don't-care bits
// - Reserved bits always read zero
// - Read-only bits ignore writes; rw bits store
// - Hardware-modifiable bits: controller and hardware write
// - Lockable bits ignore writes when either lock set
// - First lock survives soft reset until cleared
// - Second lock holds until power-on reset
// - Soft reset keeps locked, restores unlocked configuration
// - Device changes only hardware-modifiable bits
// - One address per register, decoded word-wise
module sbc_regmap
    import sbc_regmap_pkg::*;
#(
    parameter logic [7:0] FAMILY_PRODUCT_ID = 8'h5a  // Arbitrary value
) (
    // Clock and resets
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    input wire logic restart_i,
    // Serial link pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o,
    // Hardware side
    input wire logic mode_hw_we_i,
    input wire logic [1:0] mode_hw_i,
    input wire logic [WC_REGS*8-1:0] status_set_i,
    input wire logic [7:0] wake_level_i,
    input wire logic [7:0] swk_status_i,
    input wire logic [7:0] swk_err_count_i,
    input wire logic [11:0] clock_recovery_avg_i,
    // Configuration outputs
    output logic [7:0] mode_ctrl_o,
    output logic [7:0] hardware_control_one_o,
    output logic [7:0] hardware_control_two_o,
    output logic [7:0] gpio_config_o,
    output logic [7:0] timer_ctrl_o,
    output logic charge_pump_enable_o,
    output logic soft_reset_o
);

    // ----------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------------------------------
    logic [2:0] pins_s;
    logic sclk_s;
    logic cs_n_s;
    logic mosi_s;
    logic sclk_prev_q;
    logic sclk_rise;
    logic sclk_fall;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i({spi_sclk_i, spi_cs_n_i, spi_mosi_i}),
        .pin_rst_val_i(3'h2),
        .sync_o(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign cs_n_s = pins_s[1];
    assign mosi_s = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // ----------------------------------------------------------------
    // Frame engine
    // ----------------------------------------------------------------
    frame_phase_e phase_q;
    frame_phase_e phase_d;
    logic [5:0] bit_cnt_q;
    logic [5:0] bit_cnt_d;
    logic [7:0] shift_q;
    logic [7:0] shift_d;
    logic [7:0] tx_q;
    logic [7:0] tx_d;
    logic [6:0] addr_q;
    logic [6:0] addr_d;
    logic wr_q;
    logic wr_d;
    logic miso_q;
    logic miso_d;
    logic acc_we;
    logic [6:0] acc_addr;
    logic [7:0] acc_data;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;

    // Byte arrives LSB first, so the mode bit is the last of the first byte
    assign acc_data = {mosi_s, shift_q[7:1]};
    assign acc_addr = addr_q;
    assign rd_addr = (bit_cnt_q == CMD_LAST_BIT) ? shift_q[7:1] : next_valid(addr_q);

    always_comb begin
        phase_d = phase_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        addr_d = addr_q;
        wr_d = wr_q;
        miso_d = miso_q;
        acc_we = 1'b0;
        if (cs_n_s) begin
            phase_d = PH_IDLE;
            bit_cnt_d = 6'h00;
            tx_d = 8'h00;
            miso_d = 1'b0;
        end else begin
            if (phase_q == PH_IDLE) begin
                phase_d = PH_CMD;
            end
            if (sclk_rise && bit_cnt_q < FRAME_LIMIT) begin
                shift_d = acc_data;
                bit_cnt_d = 6'(bit_cnt_q + 6'h01);
                if (bit_cnt_q == CMD_LAST_BIT) begin
                    addr_d = shift_q[7:1];
                    wr_d = mosi_s;
                    phase_d = PH_DATA;
                    tx_d = rd_data;
                end else if (bit_cnt_q[2:0] == 3'h7) begin
                    acc_we = wr_q;
                    addr_d = next_valid(addr_q);
                    tx_d = rd_data;
                end
            end
            // Data is launched on the falling edge, sampled by the controller at the end of the high phase
            if (sclk_fall) begin
                miso_d = tx_q[0];
                tx_d = {1'b0, tx_q[7:1]};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            phase_q <= PH_IDLE;
            bit_cnt_q <= 6'h00;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            addr_q <= 7'h00;
            wr_q <= 1'b0;
            miso_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            miso_q <= miso_d;
            sclk_prev_q <= sclk_s;
        end
    end

    assign spi_miso_o = miso_q;
    assign spi_miso_oe_o = ~cs_n_s;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [7:0] hw1_q;
    logic [7:0] hw1_d;
    logic [7:0] hw2_q;
    logic [7:0] hw2_d;
    logic [7:0] gpio_q;
    logic [7:0] gpio_d;
    logic [7:0] timer_q;
    logic [7:0] timer_d;
    logic soft_q;
    logic soft_d;
    logic locked;

    assign locked = hw1_q[LOCK0_BIT] | hw2_q[LOCK1_BIT];

    always_comb begin
        mode_d = mode_q;
        hw1_d = hw1_q;
        hw2_d = hw2_q;
        gpio_d = gpio_q;
        timer_d = timer_q;
        soft_d = 1'b0;
        if (restart_i) begin
            mode_d = (mode_q & MODE_KEEP) | (MODE_POR & ~MODE_KEEP);
            hw1_d = (hw1_q & HW1_KEEP) | (HW1_POR & ~HW1_KEEP);
            hw2_d = (hw2_q & HW2_KEEP) | (HW2_POR & ~HW2_KEEP);
            gpio_d = (gpio_q & GPIO_KEEP) | (GPIO_POR & ~GPIO_KEEP);
            timer_d = (timer_q & TIMER_KEEP) | (TIMER_POR & ~TIMER_KEEP);
        end else if (soft_q) begin
            mode_d = MODE_POR;
            timer_d = TIMER_POR;
            hw1_d = HW1_POR;
            hw1_d[LOCK0_BIT] = hw1_q[LOCK0_BIT];
            hw1_d[CHARGE_PUMP_ENABLE_BIT_BIT] = locked ? hw1_q[CHARGE_PUMP_ENABLE_BIT_BIT] : HW1_POR[CHARGE_PUMP_ENABLE_BIT_BIT];
            hw2_d = HW2_POR;
            hw2_d[LOCK1_BIT] = hw2_q[LOCK1_BIT];
            gpio_d = locked ? gpio_q : GPIO_POR;
        end else begin
            if (acc_we) begin
                // Unmapped and read-only addresses take no write
                unique case (acc_addr)
                    ADDR_MODE: begin
                        mode_d = acc_data & MODE_MASK;
                        soft_d = acc_data[MODE_LSB +: 2] == MODE_SOFT_RESET;
                    end
                    ADDR_HW1: begin
                        hw1_d = acc_data & HW1_MASK;
                        if (locked) begin
                            hw1_d[CHARGE_PUMP_ENABLE_BIT_BIT] = hw1_q[CHARGE_PUMP_ENABLE_BIT_BIT];
                        end
                    end
                    ADDR_HW2: begin
                        hw2_d = (acc_data & HW2_MASK) | (hw2_q & (8'h01 << LOCK1_BIT));
                    end
                    ADDR_GPIO: begin
                        gpio_d = locked ? gpio_q : (acc_data & GPIO_MASK);
                    end
                    ADDR_TIMER: begin
                        timer_d = acc_data & TIMER_MASK;
                    end
                    default: begin
                    end
                endcase
            end
            // Only the mode field may be moved by the device itself
            if (mode_hw_we_i) begin
                mode_d[MODE_LSB +: 2] = mode_hw_i;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            mode_q <= MODE_POR;
            hw1_q <= HW1_POR;
            hw2_q <= HW2_POR;
            gpio_q <= GPIO_POR;
            timer_q <= TIMER_POR;
            soft_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            hw1_q <= hw1_d;
            hw2_q <= hw2_d;
            gpio_q <= gpio_d;
            timer_q <= timer_d;
            soft_q <= soft_d;
        end
    end

    assign mode_ctrl_o = mode_q;
    assign hardware_control_one_o = hw1_q;
    assign hardware_control_two_o = hw2_q;
    assign gpio_config_o = gpio_q;
    assign timer_ctrl_o = timer_q;
    assign charge_pump_enable_o = hw1_q[CHARGE_PUMP_ENABLE_BIT_BIT];
    assign soft_reset_o = soft_q;

    // ----------------------------------------------------------------
    // Status flags and read path
    // ----------------------------------------------------------------
    logic [WC_REGS-1:0] wc_clear;
    logic [WC_REGS*8-1:0] wc_flags;

    always_comb begin
        for (int i = 0; i < WC_REGS; i++) begin
            wc_clear[i] = acc_we && acc_addr == WC_ADDRS[i];
        end
    end

    status_flags #(
        .REGS(WC_REGS),
        .VALID(WC_VALID),
        .RESET_VAL(WC_RESET)
    ) u_status_flags (
        .ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i),
        .set_i(status_set_i),
        .clear_i(wc_clear),
        .flags_o(wc_flags)
    );

    // Reserved positions masked on every read
    always_comb begin
        rd_data = 8'h00;
        unique case (rd_addr)
            ADDR_MODE: rd_data = mode_q & MODE_MASK;
            ADDR_HW1: rd_data = hw1_q & HW1_MASK;
            ADDR_HW2: rd_data = hw2_q & HW2_MASK;
            ADDR_GPIO: rd_data = gpio_q & GPIO_MASK;
            ADDR_TIMER: rd_data = timer_q & TIMER_MASK;
            ADDR_WAKE_LVL: rd_data = wake_level_i & WAKE_LVL_MASK;
            ADDR_SELECTIVE_WAKE_STATUS: rd_data = swk_status_i & SELECTIVE_WAKE_STATUS_MASK;
            ADDR_ECNT: rd_data = swk_err_count_i & ECNT_MASK;
            ADDR_CDR_HIGH: rd_data = clock_recovery_avg_i[11:4];
            ADDR_CDR_LOW: rd_data = {clock_recovery_avg_i[3:0], 4'h0} & CDR_LOW_MASK;
            ADDR_FAM_PROD: rd_data = FAMILY_PRODUCT_ID;
            default: begin
                for (int i = 0; i < WC_REGS; i++) begin
                    if (rd_addr == WC_ADDRS[i]) begin
                        rd_data = wc_flags[i*8 +: 8];
                    end
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_cmd_byte;
        sclk_rise && !cs_n_s && bit_cnt_q == CMD_LAST_BIT;
    endsequence

    sequence s_data_byte;
        sclk_rise && !cs_n_s && bit_cnt_q > CMD_LAST_BIT && bit_cnt_q < FRAME_LIMIT &&
            bit_cnt_q[2:0] == 3'h7;
    endsequence

    cmd_capture_a: assert property (s_cmd_byte |=> addr_q == $past(shift_q[7:1]) && wr_q == $past(mosi_s) && phase_q == PH_DATA) else $error("command byte not captured");
    read_only_a: assert property (s_data_byte ##0 !wr_q && !restart_i && !soft_q |=> $stable(timer_q) && $stable(gpio_q) && $stable(hw1_q)) else $error("read access changed a register");
    write_store_a: assert property (s_data_byte ##0 wr_q && addr_q == ADDR_TIMER && !restart_i && !soft_q |=> timer_q == $past(acc_data)) else $error("write data not stored");
    miso_order_a: assert property (sclk_fall && !cs_n_s |=> spi_miso_o == $past(tx_q[0]) && tx_q[7] == 1'b0) else $error("read bit order wrong");
    next_addr_a: assert property (s_data_byte |=> addr_q == next_valid($past(addr_q))) else $error("address did not advance");
    por_value_a: assert property ($fell(sys_rst_i) |-> mode_q == MODE_POR && hw2_q == HW2_POR && gpio_q == GPIO_POR) else $error("power-on value wrong");
    restart_keep_a: assert property (restart_i |=> mode_q[1:0] == $past(mode_q[1:0]) && timer_q == TIMER_POR) else $error("restart value wrong");
    reserved_zero_a: assert property (s_cmd_byte |=> (tx_q & ~8'(MODE_MASK)) == 8'h00 || addr_q != ADDR_MODE) else $error("reserved bit read as one");
    lock_hold_a: assert property (locked && acc_we && acc_addr == ADDR_GPIO |=> $stable(gpio_q) [*2]) else $error("locked field took a write");
    lock1_sticky_a: assert property (hw2_q[LOCK1_BIT] |=> hw2_q[LOCK1_BIT]) else $error("second lock dropped");
    soft_keep_a: assert property (soft_q && locked && !restart_i |=> gpio_q == $past(gpio_q) && mode_q == MODE_POR) else $error("soft reset lost locked value");
    flag_latch_a: assert property (status_set_i[8] |=> wc_flags[8] ##1 (wc_flags[8] || $past(wc_clear[1]))) else $error("status flag not latched");

endmodule : sbc_regmap

/* File: hdl/sbc_regmap_pkg.sv */
package sbc_regmap_pkg;

    // ----------------------------------------------------------------
    // Frame layout
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int LONG_FRAME_BITS = 32;
    localparam logic [5:0] CMD_LAST_BIT = 6'h07;
    localparam logic [5:0] FRAME_LIMIT = 6'h20;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_CMD = 2'b01,
        PH_DATA = 2'b10
    } frame_phase_e;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [6:0] ADDR_MODE = 7'h01;
    localparam logic [6:0] ADDR_TIMER = 7'h0c;
    localparam logic [6:0] ADDR_HW1 = 7'h0e;
    localparam logic [6:0] ADDR_HW2 = 7'h0f;
    localparam logic [6:0] ADDR_GPIO = 7'h17;
    localparam logic [6:0] ADDR_WAKE_LVL = 7'h47;
    localparam logic [6:0] ADDR_SELECTIVE_WAKE_STATUS = 7'h70;
    localparam logic [6:0] ADDR_ECNT = 7'h71;
    localparam logic [6:0] ADDR_CDR_HIGH = 7'h72;
    localparam logic [6:0] ADDR_CDR_LOW = 7'h73;
    localparam logic [6:0] ADDR_FAM_PROD = 7'h7e;

    // Write-to-clear status registers, index 0 listed last
    localparam int WC_REGS = 10;
    localparam logic [WC_REGS-1:0][6:0] WC_ADDRS = {
        7'h55, 7'h54, 7'h46, 7'h45, 7'h44, 7'h43, 7'h42, 7'h41, 7'h40, 7'h3f
    };
    localparam logic [WC_REGS*8-1:0] WC_VALID = {
        8'h40, 8'h40, 8'h10, 8'h31, 8'h1f, 8'hcf, 8'h0f, 8'h9d, 8'h63, 8'h00
    };
    // Supply-low register carries the power-on flag set at reset
    localparam logic [WC_REGS*8-1:0] WC_RESET = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00
    };

    // ----------------------------------------------------------------
    // Field positions, masks, reset and restart values
    // ----------------------------------------------------------------
    localparam int MODE_LSB = 6;
    localparam logic [1:0] MODE_SOFT_RESET = 2'b11;
    localparam int CHARGE_PUMP_ENABLE_BIT_BIT = 2;
    localparam int LOCK0_BIT = 5;
    localparam int LOCK1_BIT = 0;

    localparam logic [7:0] MODE_MASK = 8'hdf;
    localparam logic [7:0] HW1_MASK = 8'h2f;
    localparam logic [7:0] HW2_MASK = 8'he1;
    localparam logic [7:0] GPIO_MASK = 8'h07;
    localparam logic [7:0] TIMER_MASK = 8'hff;
    localparam logic [7:0] WAKE_LVL_MASK = 8'hd1;
    localparam logic [7:0] SELECTIVE_WAKE_STATUS_MASK = 8'h4f;
    localparam logic [7:0] ECNT_MASK = 8'h3f;
    localparam logic [7:0] CDR_LOW_MASK = 8'hf0;

    localparam logic [7:0] MODE_POR = 8'h00;
    localparam logic [7:0] HW1_POR = 8'h00;
    localparam logic [7:0] HW2_POR = 8'h00;
    localparam logic [7:0] GPIO_POR = 8'h00;
    localparam logic [7:0] TIMER_POR = 8'h00;

    // Bits set here keep their value over a restart
    localparam logic [7:0] MODE_KEEP = 8'h03;
    localparam logic [7:0] HW1_KEEP = 8'h24;
    localparam logic [7:0] HW2_KEEP = 8'he1;
    localparam logic [7:0] GPIO_KEEP = 8'h07;
    localparam logic [7:0] TIMER_KEEP = 8'h00;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic addr_valid(input logic [6:0] a);
        logic v;
        v = 1'b0;
        for (int i = 0; i < WC_REGS; i++) begin
            if (a == WC_ADDRS[i]) begin
                v = 1'b1;
            end
        end
        if (a == ADDR_MODE || a == ADDR_TIMER || a == ADDR_HW1 || a == ADDR_HW2 ||
            a == ADDR_GPIO || a == ADDR_WAKE_LVL || a == ADDR_SELECTIVE_WAKE_STATUS ||
            a == ADDR_ECNT || a == ADDR_CDR_HIGH || a == ADDR_CDR_LOW ||
            a == ADDR_FAM_PROD) begin
            v = 1'b1;
        end
        return v;
    endfunction : addr_valid

    function automatic logic [6:0] next_valid(input logic [6:0] a);
        logic [6:0] r;
        logic [6:0] c;
        r = a;
        for (int i = 127; i >= 1; i--) begin
            c = 7'(a + 7'(i));
            if (addr_valid(c)) begin
                r = c;
            end
        end
        return r;
    endfunction : next_valid

endpackage : sbc_regmap_pkg

/* File: hdl/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Pins
    input wire logic [WIDTH-1:0] pin_i,
    input wire logic [WIDTH-1:0] pin_rst_val_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = sys_rst_i ? pin_rst_val_i : pin_i;
        sync_d = sys_rst_i ? pin_rst_val_i : meta_q;
    end

    always_ff @(posedge ref_clk_i) begin
        meta_q <= meta_d;
        sync_q <= sync_d;
    end

    assign sync_o = sync_q;
endmodule : pin_sync

/* File: hdl/status_flags.sv */
`timescale 1ns/1ps
module status_flags #(
    parameter int REGS = 10,
    parameter logic [REGS*8-1:0] VALID = '1,
    parameter logic [REGS*8-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic sys_rst_i,
    // Events and clears
    input wire logic [REGS*8-1:0] set_i,
    input wire logic [REGS-1:0] clear_i,
    // Flags
    output logic [REGS*8-1:0] flags_o
);
    logic [REGS*8-1:0] flags_q;
    logic [REGS*8-1:0] flags_d;

    // Event in the clearing cycle survives the clear
    always_comb begin
        for (int r = 0; r < REGS; r++) begin
            flags_d[r*8 +: 8] = ((clear_i[r] ? 8'h00 : flags_q[r*8 +: 8]) | set_i[r*8 +: 8])
                                & VALID[r*8 +: 8];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            flags_q <= RESET_VAL & VALID;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags_o = flags_q;
endmodule : status_flags

/* File: sim/spi_ctrl_model.sv */
`timescale 1ns/1ps
module spi_ctrl_model (
    // Clock
    input wire logic ref_clk_i,
    // Serial pins
    output logic spi_sclk_o,
    output logic spi_cs_n_o,
    output logic spi_mosi_o,
    input wire logic spi_miso_i,
    // Read result
    output logic rd_done_o,
    output logic [7:0] rd_byte_o
);
    initial begin
        spi_sclk_o = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_mosi_o = 1'b0;
        rd_done_o = 1'b0;
        rd_byte_o = 8'h00;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : tick

    // Half period of 4 clocks gives the 64 ns link clock; clock idles low
    task automatic xfer(input int nbits, input logic [31:0] tx);
        logic [31:0] rx;
        rx = '0;
        spi_cs_n_o = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_mosi_o = tx[i];
            tick(4);
            spi_sclk_o = 1'b1;
            tick(4);
            // Taken at the end of the high phase, before the next shift
            rx[i] = spi_miso_i;
            spi_sclk_o = 1'b0;
        end
        tick(4);
        spi_cs_n_o = 1'b1;
        // Released line never shows a stale copy of the last bit
        spi_mosi_o = ~spi_mosi_o;
        rd_byte_o = rx[15:8];
        rd_done_o = ~tx[7];
        tick(1);
        rd_done_o = 1'b0;
        tick(4);
    endtask : xfer
endmodule : spi_ctrl_model

/* File: sim/spi_register_access_and_status_map_bench.sv */
`timescale 1ns/1ps
module spi_register_access_and_status_map_bench;
    import sbc_regmap_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic restart = 1'b0;
    logic sclk, cs_n, mosi, miso, miso_oe, rd_done, charge_pump_enable_bit, soft_rst;
    logic [7:0] rd_byte, mode_ctrl, hw1, hw2, gpio, timer, r;
    logic mode_hw_we = 1'b0;
    logic [1:0] mode_hw = 2'b00;
    logic [79:0] set_ev = '0;
    logic [7:0] lvl = 8'h00;
    logic [7:0] swk = 8'h00;
    logic [7:0] ecnt = 8'h00;
    logic [11:0] cdr = 12'h000;
    logic [14:0] note;
    logic [14:0] exp_q[$];
    int err_count = 0;
    int check_count = 0;
    int sr_n = 0;
    int n;

    always #4 ref_clk_i = ~ref_clk_i;

    sbc_regmap #(.FAMILY_PRODUCT_ID(8'h3c)) dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .restart_i(restart),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe),
        .mode_hw_we_i(mode_hw_we), .mode_hw_i(mode_hw), .status_set_i(set_ev),
        .wake_level_i(lvl), .swk_status_i(swk), .swk_err_count_i(ecnt),
        .clock_recovery_avg_i(cdr), .mode_ctrl_o(mode_ctrl),
        .hardware_control_one_o(hw1), .hardware_control_two_o(hw2),
        .gpio_config_o(gpio), .timer_ctrl_o(timer),
        .charge_pump_enable_o(charge_pump_enable_bit), .soft_reset_o(soft_rst)
    );

    spi_ctrl_model u_ctrl (
        .ref_clk_i(ref_clk_i), .spi_sclk_o(sclk), .spi_cs_n_o(cs_n), .spi_mosi_o(mosi),
        .spi_miso_i(miso), .rd_done_o(rd_done), .rd_byte_o(rd_byte)
    );

    // ----------------------------------------------------------------
    // Checking
    // ----------------------------------------------------------------
    task automatic end_sim();
        if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [7:0] e, input logic [7:0] got);
        check_count++;
        if (got !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, e, got);
        end
    endtask : chk

    always @(posedge ref_clk_i) begin
        if (soft_rst === 1'b1) sr_n++;
        if (rd_done === 1'b1) begin
            note = exp_q.pop_front();
            chk($sformatf("read of %h", note[14:8]), note[7:0], rd_byte);
        end
    end

    initial begin
        repeat (100000) @(posedge ref_clk_i);
        err_count++;
        end_sim();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_ctrl.xfer(16, {16'h0000, d, 1'b1, a});
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back({a, e});
        u_ctrl.xfer(16, {24'h000000, 1'b0, a});
    endtask : rd

    task automatic do_rst();
        sys_rst_i = 1'b1;
        u_ctrl.tick(8);
        sys_rst_i = 1'b0;
        u_ctrl.tick(2);
    endtask : do_rst

    initial begin
        void'($urandom(32'h7a9a29a3));
        do_rst();
        chk("miso enable", 8'h00, {7'h00, miso_oe});
        rd(7'h41, 8'h80);
        rd(7'h0e, 8'h00);
        wr(7'h7e, 8'hff);
        rd(7'h7e, 8'h3c);
        rd(7'h7f, 8'h00);
        // Levels change between rounds so stale read data cannot pass
        repeat (2) begin
            lvl = 8'($urandom());
            swk = 8'($urandom());
            ecnt = 8'($urandom());
            cdr = 12'($urandom());
            rd(ADDR_WAKE_LVL, lvl & WAKE_LVL_MASK);
            rd(ADDR_SELECTIVE_WAKE_STATUS, swk & SELECTIVE_WAKE_STATUS_MASK);
            rd(ADDR_ECNT, ecnt & ECNT_MASK);
            rd(ADDR_CDR_HIGH, cdr[11:4]);
            rd(ADDR_CDR_LOW, {cdr[3:0], 4'h0});
        end
        r = 8'($urandom());
        wr(7'h0c, r);
        rd(7'h0c, r);
        wr(7'h01, 8'h1d);
        rd(7'h01, 8'h1d);
        // Event flag latches after a one-cycle pulse
        r = 8'($urandom()) | 8'h01;
        set_ev[23:8] = {8'hff, r};
        u_ctrl.tick(1);
        set_ev = '0;
        rd(7'h40, r & WC_VALID[15:8]);
        rd(7'h41, 8'h9d);
        rd(7'h41, 8'h9d);
        wr(7'h41, 8'h00);
        rd(7'h41, 8'h00);
        u_ctrl.xfer(32, {8'h05, 8'h00, 8'h04, 1'b1, 7'h0e});
        chk("charge pump", 8'h01, {7'h00, charge_pump_enable_bit});
        chk("gpio", 8'h05, gpio);
        wr(7'h0e, 8'h24);
        wr(7'h17, 8'h02);
        chk("gpio", 8'h05, gpio);
        n = sr_n;
        wr(7'h01, 8'hc0);
        chk("soft reset", 8'(n + 1), 8'(sr_n));
        chk("hw1", 8'h24, hw1);
        chk("gpio", 8'h05, gpio);
        chk("timer", 8'h00, timer);
        chk("mode", 8'h00, mode_ctrl);
        wr(7'h0e, 8'h00);
        chk("first lock", 8'h00, {7'h00, hw1[5]});
        wr(7'h0f, 8'h01);
        wr(7'h17, 8'h03);
        chk("gpio", 8'h05, gpio);
        wr(7'h01, 8'hc0);
        chk("hw2", 8'h01, hw2);
        mode_hw_we = 1'b1;
        mode_hw = 2'($urandom());
        u_ctrl.tick(1);
        mode_hw_we = 1'b0;
        u_ctrl.tick(1);
        chk("mode field", {6'h00, mode_hw}, {6'h00, mode_ctrl[7:6]});
        wr(7'h0c, r | 8'h01);
        restart = 1'b1;
        u_ctrl.tick(1);
        restart = 1'b0;
        u_ctrl.tick(2);
        chk("timer", 8'h00, timer);
        chk("hw2", 8'h01, hw2);
        chk("mode", 8'h00, mode_ctrl);
        do_rst();
        chk("hw2", 8'h00, hw2);
        chk("gpio", 8'h00, gpio);
        end_sim();
    end
endmodule : spi_register_access_and_status_map_bench
